/* File: proximity_threshold_config_regs.sv */
// What this block does
// - interrupt when result leaves threshold window
// - low threshold from bytes 0x08, 0x09
// - high threshold from bytes 0x0a, 0x0b
// - filter selects every-result or persistent interrupt
// - long-wait bit stretches wait twelvefold
// - emit programmed pulse count at 62.5 kHz
// - bits 7:6 select emitter drive current
// - bits 5:4 select photodiode, code 11 stored as written
// - bits 3:2 select proximity gain
// - revision read-only, upper nibble zero
// - identification read-only, writes ignored
// - interrupt raised only while mask bit set
// - wait counts in 2.73 ms steps
`timescale 1ns/1ps
`default_nettype none

module proximity_threshold_config_regs
	import prox_cfg_pkg::*;
#(
	parameter int WAIT_STEP_CYCLES = WAIT_STEP_CYC, // cycles per wait step
	parameter logic [3:0] DIE_REVISION = 4'h1, // arbitrary value
	parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
) (
	input wire logic core_clk_i, // core clock, 250 MHz
	input wire logic rst_i, // async reset, active high
	input wire logic [7:0] reg_addr_i, // register offset
	input wire logic reg_wr_i, // write strobe
	input wire logic reg_rd_i, // read strobe
	input wire logic [7:0] reg_wdata_i, // write data
	output logic [7:0] reg_rdata_o, // read data, one cycle after strobe
	input wire logic threshold_irq_mask_i, // interrupt mask from enable register
	input wire logic irq_clear_i, // clears pending interrupt
	input wire logic [15:0] prox_result_i, // completed proximity result
	input wire logic prox_valid_i, // result strobe
	output logic prox_irq_o, // proximity interrupt, level
	input wire logic [7:0] wait_period_setting_i, // wait time register value
	input wire logic wait_start_i, // starts a wait period
	output logic wait_busy_o, // wait in progress
	output logic wait_done_o, // wait over, one cycle
	input wire logic pulse_start_i, // starts a pulse burst
	output logic emitter_led_o, // emitter drive gate
	output logic pulse_busy_o, // burst in progress
	output logic pulse_done_o, // burst over, one cycle
	output logic [1:0] emitter_current_code_o, // drive strength code
	output logic [1:0] photodiode_select_o, // diode selection code
	output logic [1:0] front_end_gain_o // gain code
);

	localparam int WAIT_STEPS_CYCLES_M1 = WAIT_STEP_CYCLES - 1;
	localparam logic [19:0] STEP_LAST = 20'(WAIT_STEPS_CYCLES_M1);
	localparam logic [3:0] LONG_LAST = 4'(WAIT_LONG_FACTOR - 1);
	localparam logic [8:0] STEPS_FULL = 9'(WAIT_STEPS_FULL);
	localparam logic [11:0] PERIOD_LAST = 12'(PULSE_PERIOD_CYC - 1);
	localparam logic [11:0] HIGH_LAST = 12'(PULSE_HIGH_CYC - 1);

	// register storage
	logic [7:0] low_limit_lo_r;
	logic [7:0] low_limit_hi_r;
	logic [7:0] high_limit_lo_r;
	logic [7:0] high_limit_hi_r;
	logic [7:0] interrupt_filter_r;
	logic wait_x12_select_r;
	logic [7:0] emitter_pulse_count_r;
	logic [5:0] analog_control_r;
	logic [7:0] rdata_nxt;

	// wait timer state
	logic [19:0] step_cnt_r;
	logic [8:0] steps_left_r;
	logic [3:0] long_cnt_r;

	// pulse burst state
	logic [11:0] phase_cnt_r;
	logic [7:0] pulses_left_r;

	thr_if thr ();

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_limit_lo_r <= RST_LIMIT_BYTE;
			low_limit_hi_r <= RST_LIMIT_BYTE;
		end else if (reg_wr_i) begin
			if (reg_addr_i == OFS_LOW_LIMIT_LO) begin
				low_limit_lo_r <= reg_wdata_i;
			end
			if (reg_addr_i == OFS_LOW_LIMIT_HI) begin
				low_limit_hi_r <= reg_wdata_i;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			high_limit_lo_r <= RST_LIMIT_BYTE;
			high_limit_hi_r <= RST_LIMIT_BYTE;
		end else if (reg_wr_i) begin
			if (reg_addr_i == OFS_HIGH_LIMIT_LO) begin
				high_limit_lo_r <= reg_wdata_i;
			end
			if (reg_addr_i == OFS_HIGH_LIMIT_HI) begin
				high_limit_hi_r <= reg_wdata_i;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			interrupt_filter_r <= RST_INTERRUPT_FILTER;
		end else if (reg_wr_i && (reg_addr_i == OFS_INTERRUPT_FILTER)) begin
			interrupt_filter_r <= reg_wdata_i;
		end
	end

	// only the long-wait bit is stored
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_x12_select_r <= RST_WAIT_SCALE_CONFIG[WAIT_X12_SELECT_BIT];
		end else if (reg_wr_i && (reg_addr_i == OFS_WAIT_SCALE_CONFIG)) begin
			wait_x12_select_r <= reg_wdata_i[WAIT_X12_SELECT_BIT];
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			emitter_pulse_count_r <= RST_EMITTER_PULSE_COUNT;
		end else if (reg_wr_i && (reg_addr_i == OFS_EMITTER_PULSE_COUNT)) begin
			emitter_pulse_count_r <= reg_wdata_i;
		end
	end

	// analog control bits 7:2; bits 1:0 are reserved and read zero
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			analog_control_r <= RST_ANALOG_CONTROL[EMITTER_CURRENT_MSB:FRONT_END_GAIN_LSB];
		end else if (reg_wr_i && (reg_addr_i == OFS_ANALOG_CONTROL)) begin
			// code 11 is stored as written
			analog_control_r <= reg_wdata_i[EMITTER_CURRENT_MSB:FRONT_END_GAIN_LSB];
		end
	end

	// codes to the analog front end, straight from flops
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			emitter_current_code_o <= RST_ANALOG_CONTROL[EMITTER_CURRENT_MSB:EMITTER_CURRENT_LSB];
			photodiode_select_o <= RST_ANALOG_CONTROL[PHOTODIODE_SEL_MSB:PHOTODIODE_SEL_LSB];
			front_end_gain_o <= RST_ANALOG_CONTROL[FRONT_END_GAIN_MSB:FRONT_END_GAIN_LSB];
		end else begin
			emitter_current_code_o <= analog_control_r[5:4];
			photodiode_select_o <= analog_control_r[3:2];
			front_end_gain_o <= analog_control_r[1:0];
		end
	end

	// read multiplexer; unmapped offsets read zero
	always_comb begin
		rdata_nxt = UNMAPPED_READ;
		unique case (reg_addr_i)
			OFS_LOW_LIMIT_LO: rdata_nxt = low_limit_lo_r;
			OFS_LOW_LIMIT_HI: rdata_nxt = low_limit_hi_r;
			OFS_HIGH_LIMIT_LO: rdata_nxt = high_limit_lo_r;
			OFS_HIGH_LIMIT_HI: rdata_nxt = high_limit_hi_r;
			OFS_INTERRUPT_FILTER: rdata_nxt = interrupt_filter_r;
			OFS_WAIT_SCALE_CONFIG: rdata_nxt = {6'h00, wait_x12_select_r, 1'b0};
			OFS_EMITTER_PULSE_COUNT: rdata_nxt = emitter_pulse_count_r;
			OFS_ANALOG_CONTROL: rdata_nxt = {analog_control_r, 2'b00};
			OFS_SILICON_REVISION: rdata_nxt = {4'h0, DIE_REVISION};
			OFS_PART_IDENTIFICATION: rdata_nxt = PART_ID;
			default: rdata_nxt = UNMAPPED_READ;
		endcase
	end

	// read data register, holds until the next read
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= UNMAPPED_READ;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_nxt;
		end
	end

	// threshold comparator and persistence filter
	assign thr.low_limit = {low_limit_hi_r, low_limit_lo_r};
	assign thr.high_limit = {high_limit_hi_r, high_limit_lo_r};
	assign thr.filter = interrupt_filter_r;
	assign thr.result = prox_result_i;
	assign thr.result_valid = prox_valid_i;
	assign thr.irq_mask = threshold_irq_mask_i;
	assign thr.irq_clear = irq_clear_i;
	assign prox_irq_o = thr.irq;

	threshold_engine u_engine (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.thr(thr.engine)
	);

	// wait timer: (256 - setting) steps, each twelve times longer when selected
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			step_cnt_r <= 20'h00000;
			steps_left_r <= 9'h000;
			long_cnt_r <= 4'h0;
			wait_busy_o <= 1'b0;
			wait_done_o <= 1'b0;
		end else begin
			wait_done_o <= 1'b0;
			if (wait_start_i && !wait_busy_o) begin
				step_cnt_r <= 20'h00000;
				steps_left_r <= STEPS_FULL - {1'b0, wait_period_setting_i};
				long_cnt_r <= 4'h0;
				wait_busy_o <= 1'b1;
			end else if (wait_busy_o) begin
				if (step_cnt_r == STEP_LAST) begin
					step_cnt_r <= 20'h00000;
					if (!wait_x12_select_r || (long_cnt_r == LONG_LAST)) begin
						long_cnt_r <= 4'h0;
						if (steps_left_r == 9'h001) begin
							wait_busy_o <= 1'b0;
							wait_done_o <= 1'b1;
						end else begin
							steps_left_r <= steps_left_r - 9'h001;
						end
					end else begin
						long_cnt_r <= long_cnt_r + 4'h1;
					end
				end else begin
					step_cnt_r <= step_cnt_r + 20'h00001;
				end
			end
		end
	end

	// pulse burst: led high for the first half of each 16 us period
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_cnt_r <= 12'h000;
			pulses_left_r <= 8'h00;
			emitter_led_o <= 1'b0;
			pulse_busy_o <= 1'b0;
			pulse_done_o <= 1'b0;
		end else begin
			pulse_done_o <= 1'b0;
			if (pulse_start_i && !pulse_busy_o) begin
				// a zero count finishes at once with no pulse
				if (emitter_pulse_count_r == 8'h00) begin
					pulse_done_o <= 1'b1;
				end else begin
					phase_cnt_r <= 12'h000;
					pulses_left_r <= emitter_pulse_count_r;
					emitter_led_o <= 1'b1;
					pulse_busy_o <= 1'b1;
				end
			end else if (pulse_busy_o) begin
				// count pulses at the set rate
				if (phase_cnt_r == PERIOD_LAST) begin
					phase_cnt_r <= 12'h000;
					if (pulses_left_r == 8'h01) begin
						pulse_busy_o <= 1'b0;
						pulse_done_o <= 1'b1;
						emitter_led_o <= 1'b0;
					end else begin
						pulses_left_r <= pulses_left_r - 8'h01;
						emitter_led_o <= 1'b1;
					end
				end else begin
					phase_cnt_r <= phase_cnt_r + 12'h001;
					if (phase_cnt_r == HIGH_LAST) begin
						emitter_led_o <= 1'b0;
					end
				end
			end
		end
	end

endmodule : proximity_threshold_config_regs

`default_nettype wire

/* File: prox_cfg_pkg.sv */
package prox_cfg_pkg;

	// register offsets
	localparam logic [7:0] OFS_LOW_LIMIT_LO = 8'h08;
	localparam logic [7:0] OFS_LOW_LIMIT_HI = 8'h09;
	localparam logic [7:0] OFS_HIGH_LIMIT_LO = 8'h0a;
	localparam logic [7:0] OFS_HIGH_LIMIT_HI = 8'h0b;
	localparam logic [7:0] OFS_INTERRUPT_FILTER = 8'h0c;
	localparam logic [7:0] OFS_WAIT_SCALE_CONFIG = 8'h0d;
	localparam logic [7:0] OFS_EMITTER_PULSE_COUNT = 8'h0e;
	localparam logic [7:0] OFS_ANALOG_CONTROL = 8'h0f;
	localparam logic [7:0] OFS_SILICON_REVISION = 8'h11;
	localparam logic [7:0] OFS_PART_IDENTIFICATION = 8'h12;

	// field positions
	localparam int WAIT_X12_SELECT_BIT = 1;
	localparam int EMITTER_CURRENT_MSB = 7;
	localparam int EMITTER_CURRENT_LSB = 6;
	localparam int PHOTODIODE_SEL_MSB = 5;
	localparam int PHOTODIODE_SEL_LSB = 4;
	localparam int FRONT_END_GAIN_MSB = 3;
	localparam int FRONT_END_GAIN_LSB = 2;

	// values after reset
	localparam logic [7:0] RST_LIMIT_BYTE = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_FILTER = 8'h00;
	localparam logic [7:0] RST_WAIT_SCALE_CONFIG = 8'h00;
	localparam logic [7:0] RST_EMITTER_PULSE_COUNT = 8'h00;
	localparam logic [7:0] RST_ANALOG_CONTROL = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// timing
	localparam int CLK_HZ = 250000000;
	localparam int CLK_MHZ = 250;
	localparam int WAIT_STEP_US = 2730;
	localparam int WAIT_STEP_CYC = WAIT_STEP_US * CLK_MHZ;
	localparam int WAIT_LONG_FACTOR = 12;
	localparam int WAIT_STEPS_FULL = 256;
	localparam int PULSE_RATE_HZ = 62500;
	localparam int PULSE_PERIOD_CYC = CLK_HZ / PULSE_RATE_HZ;
	localparam int PULSE_HIGH_CYC = PULSE_PERIOD_CYC / 2;

endpackage : prox_cfg_pkg

/* File: thr_if.sv */
`timescale 1ns/1ps
`default_nettype none

// carries limits, filter and results between the register bank and the comparator
interface thr_if;
	logic [15:0] low_limit;
	logic [15:0] high_limit;
	logic [7:0] filter;
	logic [15:0] result;
	logic result_valid;
	logic irq_mask;
	logic irq_clear;
	logic irq;

	modport ctrl (
		output low_limit, high_limit, filter, result, result_valid, irq_mask, irq_clear,
		input irq
	);
	modport engine (
		input low_limit, high_limit, filter, result, result_valid, irq_mask, irq_clear,
		output irq
	);
endinterface : thr_if

`default_nettype wire

/* File: threshold_engine.sv */
`timescale 1ns/1ps
`default_nettype none

module threshold_engine
	import prox_cfg_pkg::*;
(
	input wire logic core_clk_i, // core clock
	input wire logic rst_i, // async reset, active high
	thr_if.engine thr // limits in, interrupt out
);

	logic [7:0] persist_cnt_r;
	logic out_of_range;
	logic fire;
	logic [8:0] cnt_plus;

	assign out_of_range = (thr.result < thr.low_limit) || (thr.result > thr.high_limit);
	assign cnt_plus = {1'b0, persist_cnt_r} + 9'h001;

	assign fire = thr.result_valid &&
		((thr.filter == 8'h00) || (out_of_range && (cnt_plus >= {1'b0, thr.filter})));

	// persistence counter, cleared by any in-range result
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			persist_cnt_r <= 8'h00;
		end else if (thr.result_valid) begin
			if (!out_of_range) begin
				persist_cnt_r <= 8'h00;
			end else if (persist_cnt_r != 8'hff) begin
				persist_cnt_r <= persist_cnt_r + 8'h01;
			end
		end
	end

	// sticky interrupt; a new event beats a clear in the same cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			thr.irq <= 1'b0;
		end else if (fire && thr.irq_mask) begin
			thr.irq <= 1'b1;
		end else if (thr.irq_clear) begin
			thr.irq <= 1'b0;
		end
	end

endmodule : threshold_engine

`default_nettype wire

/* File: host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_model
	import prox_cfg_pkg::*;
(
	input wire logic core_clk_i, // core clock
	output logic [7:0] reg_addr_o, // register offset
	output logic reg_wr_o, // write strobe
	output logic reg_rd_o, // read strobe
	output logic [7:0] reg_wdata_o, // write data
	input wire logic [7:0] reg_rdata_i // read data
);
	// bus idle at time zero
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 8'h00;
	end

	// one write, strobe held for a single edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == OFS_WAIT_SCALE_CONFIG) v = d & 8'h02;
		if (a == OFS_ANALOG_CONTROL && d[5:4] == 2'b11) v[5:4] = 2'b10;
		@(posedge core_clk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = v;
		reg_wr_o = 1'b1;
		@(posedge core_clk_i);
		#1;
		reg_wr_o = 1'b0;
	endtask : wr

	// one read, data taken a cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		#1;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(posedge core_clk_i);
		#1;
		reg_rd_o = 1'b0;
		d = reg_rdata_i;
	endtask : rd
endmodule : host_model

`default_nettype wire

/* File: prox_cfg_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module prox_cfg_assertions
	import prox_cfg_pkg::*;
#(
	parameter int WAIT_STEP_CYCLES = 4,
	parameter logic [3:0] DIE_REVISION = 4'h1,
	parameter logic [7:0] PART_ID = 8'h5a
) (
	input wire logic core_clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic [7:0] reg_addr_i, // offset
	input wire logic reg_wr_i, // write
	input wire logic reg_rd_i, // read
	input wire logic [7:0] reg_wdata_i, // write data
	input wire logic [7:0] reg_rdata_o, // read data
	input wire logic threshold_irq_mask_i, // mask
	input wire logic irq_clear_i, // clear
	input wire logic prox_valid_i, // result strobe
	input wire logic prox_irq_o, // interrupt
	input wire logic [7:0] wait_period_setting_i, // wait setting
	input wire logic wait_start_i, // wait start
	input wire logic wait_busy_o, // wait busy
	input wire logic wait_done_o, // wait done
	input wire logic pulse_start_i, // burst start
	input wire logic emitter_led_o, // emitter gate
	input wire logic pulse_busy_o, // burst busy
	input wire logic pulse_done_o, // burst done
	input wire logic [1:0] emitter_current_code_o, // drive code
	input wire logic [1:0] photodiode_select_o, // diode code
	input wire logic [1:0] front_end_gain_o // gain code
);
	logic long_r;
	logic led_q_r;
	logic [7:0] pcnt_r;
	int wexp_r, wcnt_r, hi_r, pexp_r, rises_r;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	// mirrors of long-wait bit and pulse count as written
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			long_r <= 1'b0;
			pcnt_r <= 8'h00;
		end else if (reg_wr_i && reg_addr_i == OFS_WAIT_SCALE_CONFIG) begin
			long_r <= reg_wdata_i[WAIT_X12_SELECT_BIT];
		end else if (reg_wr_i && reg_addr_i == OFS_EMITTER_PULSE_COUNT) begin
			pcnt_r <= reg_wdata_i;
		end
	end

	// busy cycles of a wait against the expected length
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wcnt_r <= 0;
			wexp_r <= 0;
		end else if (wait_start_i && !wait_busy_o) begin
			wcnt_r <= 0;
			wexp_r <= (256 - int'(wait_period_setting_i)) * WAIT_STEP_CYCLES
				* (long_r ? WAIT_LONG_FACTOR : 1);
		end else if (wait_busy_o) begin
			wcnt_r <= wcnt_r + 1;
		end
	end

	// emitter high time and pulse count of a burst
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			led_q_r <= 1'b0;
			hi_r <= 0;
		end else begin
			led_q_r <= emitter_led_o;
			hi_r <= emitter_led_o ? hi_r + 1 : 0;
		end
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rises_r <= 0;
			pexp_r <= 0;
		end else if (pulse_start_i && !pulse_busy_o) begin
			rises_r <= 0;
			pexp_r <= int'(pcnt_r);
		end else if (emitter_led_o && !led_q_r) begin
			rises_r <= rises_r + 1;
		end
	end

	rev_read_a: assert property (reg_rd_i && reg_addr_i == OFS_SILICON_REVISION
		|=> reg_rdata_o == {4'h0, DIE_REVISION}) else $error("revision readback wrong");
	id_read_a: assert property (reg_rd_i && reg_addr_i == OFS_PART_IDENTIFICATION
		|=> reg_rdata_o == PART_ID) else $error("identification readback wrong");
	ctrl_fields_a: assert property (reg_wr_i && reg_addr_i == OFS_ANALOG_CONTROL
		|-> ##2 {emitter_current_code_o, photodiode_select_o, front_end_gain_o, 2'b00}
		== ($past(reg_wdata_i, 2) & 8'hfc)) else $error("analog codes differ from write");
	irq_cause_a: assert property ($rose(prox_irq_o)
		|-> $past(prox_valid_i) && $past(threshold_irq_mask_i)) else $error("interrupt without cause");
	irq_hold_a: assert property (prox_irq_o && !irq_clear_i |=> prox_irq_o)
		else $error("interrupt dropped without clear");
	irq_clear_a: assert property (prox_irq_o && irq_clear_i && !prox_valid_i
		|=> !prox_irq_o) else $error("interrupt not cleared");
	wait_go_a: assert property (wait_start_i && !wait_busy_o |=> wait_busy_o)
		else $error("wait did not start");
	wait_len_a: assert property (wait_done_o |-> !wait_busy_o && wcnt_r == wexp_r)
		else $error("wait length wrong");
	led_width_a: assert property ($fell(emitter_led_o) |-> hi_r == PULSE_HIGH_CYC)
		else $error("emitter pulse width wrong");
	pulse_count_a: assert property (pulse_done_o |-> !pulse_busy_o && rises_r == pexp_r)
		else $error("emitter pulse count wrong");

	irq_seen_c: cover property ($rose(prox_irq_o));
	wait_seen_c: cover property (wait_done_o);
	burst_seen_c: cover property (pulse_done_o && pexp_r > 0);
endmodule : prox_cfg_assertions

bind proximity_threshold_config_regs prox_cfg_assertions #(
	.WAIT_STEP_CYCLES(WAIT_STEP_CYCLES), .DIE_REVISION(DIE_REVISION), .PART_ID(PART_ID)
) chk (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.threshold_irq_mask_i(threshold_irq_mask_i), .irq_clear_i(irq_clear_i),
	.prox_valid_i(prox_valid_i), .prox_irq_o(prox_irq_o),
	.wait_period_setting_i(wait_period_setting_i), .wait_start_i(wait_start_i),
	.wait_busy_o(wait_busy_o), .wait_done_o(wait_done_o), .pulse_start_i(pulse_start_i),
	.emitter_led_o(emitter_led_o), .pulse_busy_o(pulse_busy_o), .pulse_done_o(pulse_done_o),
	.emitter_current_code_o(emitter_current_code_o), .photodiode_select_o(photodiode_select_o),
	.front_end_gain_o(front_end_gain_o)
);

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb import prox_cfg_pkg::*;;
	logic clk, rst, wr, rd, mask, clr, valid, irq, wstart, wbusy, wdone, pstart, led, pbusy, pdone;
	logic [7:0] addr, wdata, rdata, wset, v;
	logic [15:0] res_v;
	logic [1:0] ecc, pds, feg;
	logic [7:0] ofs [6] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h0d};
	logic [7:0] val [6] = '{8'h03, 8'h02, 8'h05, 8'h04, 8'h02, 8'hff};
	logic [7:0] exv [6] = '{8'h03, 8'h02, 8'h05, 8'h04, 8'h02, 8'h02};
	int errors = 0;
	int total_checks = 0;

	host_model host (.core_clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata));
	proximity_threshold_config_regs #(.WAIT_STEP_CYCLES(4)) uut (.core_clk_i(clk), .rst_i(rst),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.threshold_irq_mask_i(mask), .irq_clear_i(clr), .prox_result_i(res_v),
		.prox_valid_i(valid), .prox_irq_o(irq), .wait_period_setting_i(wset),
		.wait_start_i(wstart), .wait_busy_o(wbusy), .wait_done_o(wdone), .pulse_start_i(pstart),
		.emitter_led_o(led), .pulse_busy_o(pbusy), .pulse_done_o(pdone),
		.emitter_current_code_o(ecc), .photodiode_select_o(pds), .front_end_gain_o(feg));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask : rchk

	// one result, then look at the interrupt and clear it
	task automatic res(input logic [15:0] r, input logic exp);
		@(posedge clk);
		#1;
		res_v = r;
		valid = 1'b1;
		@(posedge clk);
		#1;
		valid = 1'b0;
		@(posedge clk);
		#1;
		chk({15'h0, irq}, {15'h0, exp});
		clr = 1'b1;
		@(posedge clk);
		#1;
		clr = 1'b0;
	endtask : res

	// start a wait or a burst and count cycles to its done pulse
	task automatic op(input bit pulse, input int exp);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		if (pulse) pstart = 1'b1;
		else wstart = 1'b1;
		@(posedge clk);
		#1;
		pstart = 1'b0;
		wstart = 1'b0;
		while (!(pulse ? pdone : wdone) && n < 20000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(16'(n), 16'(exp));
	endtask : op

	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop

	// hang guard
	initial begin
		#200000;
		errors++;
		report_and_stop();
	end

	initial begin
		{mask, clr, valid, wstart, pstart} = 5'h00;
		res_v = 16'h0000;
		wset = 8'h00;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 8; i < 16; i++) rchk(8'(i), 8'h00);
		for (int i = 0; i < 6; i++) host.wr(ofs[i], val[i]);
		for (int i = 0; i < 6; i++) rchk(ofs[i], exv[i]);
		host.wr(OFS_SILICON_REVISION, 8'hff);
		host.wr(OFS_PART_IDENTIFICATION, 8'h00);
		host.wr(8'h10, 8'h77);
		rchk(OFS_SILICON_REVISION, 8'h01);
		rchk(OFS_PART_IDENTIFICATION, 8'h5a);
		rchk(8'h10, UNMAPPED_READ);
		// every drive and gain code, diode codes 00 to 10
		for (int i = 0; i < 4; i++) begin
			v = {2'(i), (i == 3) ? 2'b10 : 2'(i), ~2'(i), 2'b11};
			host.wr(OFS_ANALOG_CONTROL, v);
			@(posedge clk);
			#1;
			chk({10'h0, ecc, pds, feg}, {8'h00, v >> 2});
			rchk(OFS_ANALOG_CONTROL, v & 8'hfc);
		end
		mask = 1'b1;
		res(16'h0300, 1'b1);
		host.wr(OFS_INTERRUPT_FILTER, 8'h01);
		res(16'h0203, 1'b0);
		res(16'h0202, 1'b1);
		res(16'h0405, 1'b0);
		res(16'h0406, 1'b1);
		res(16'h0300, 1'b0);
		mask = 1'b0;
		res(16'h0000, 1'b0);
		mask = 1'b1;
		host.wr(OFS_INTERRUPT_FILTER, 8'h03);
		res(16'h0300, 1'b0);
		res(16'h0000, 1'b0);
		res(16'hffff, 1'b0);
		res(16'h0300, 1'b0);
		res(16'h0000, 1'b0);
		res(16'h0000, 1'b0);
		res(16'h0000, 1'b1);
		host.wr(OFS_WAIT_SCALE_CONFIG, 8'h00);
		wset = 8'hfe;
		op(1'b0, 2 * 4);
		host.wr(OFS_WAIT_SCALE_CONFIG, 8'h02);
		wset = 8'hff;
		op(1'b0, 12 * 4);
		op(1'b1, 2 * 4000);
		host.wr(OFS_EMITTER_PULSE_COUNT, 8'h00);
		op(1'b1, 0);
		report_and_stop();
	end
endmodule : tb

`default_nettype wire
